// ===== awc_pkg.sv
// Shared constants and types for the working-register execution core
package awc_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int ADDR_W = 8;
    localparam int STACK_DEPTH = 8;

    // ========================================================================
    // Vectors and reset values
    // ========================================================================
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] FSR_RST = 8'h00;
    localparam logic [13:0] INSTR_NOP = 14'h0000;

    // ========================================================================
    // Core registers in data space (low seven address bits, both banks)
    // ========================================================================
    localparam logic [6:0] SFR_INDIRECT = 7'h00;
    localparam logic [6:0] SFR_PCL = 7'h02;
    localparam logic [6:0] SFR_STATUS = 7'h03;
    localparam logic [6:0] SFR_FSR = 7'h04;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_RP0 = 5;

    // ========================================================================
    // Instruction encoding
    // ========================================================================
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [13:0] INSTR_RETURN = 14'h0008;
    localparam logic [13:0] INSTR_RETFIE = 14'h0009;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLK_NS = 25;
    localparam int PHASE_COUNT = 4;
    localparam int CYCLE_NS_REF = 200;
    localparam int OSC_MHZ_REF = 20;
    localparam int CYCLE_NS = PHASE_COUNT * CLK_NS;

    // Phase sequence, Gray coded
    typedef enum logic [1:0] {
        PH_ONE = 2'h0,
        PH_TWO = 2'h1,
        PH_THREE = 2'h3,
        PH_FOUR = 2'h2
    } awc_phase_t;

    // ALU operations
    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_PASS_W, ALU_PASS_F,
        ALU_COM, ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_CLR,
        ALU_BCLR, ALU_BSET
    } awc_alu_op_t;

endpackage

// ===== awc_alu.sv
// Eight-bit ALU with carry, digit carry and zero outputs
`timescale 1ns/100ps
module awc_alu (
    // Operation select
    input wire awc_pkg::awc_alu_op_t i_op,
    input wire logic [2:0] i_bit,
    input wire logic i_carry,
    // Operands: working register and file or literal
    input wire logic [7:0] i_w,
    input wire logic [7:0] i_f,
    // Result and flags
    output logic [7:0] o_res,
    output logic o_c,
    output logic o_dc,
    output logic o_z
);
    logic [8:0] sum;
    logic [4:0] nib;

    // Operation select and flag generation
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        o_c = i_carry;
        o_dc = 1'b0;
        o_res = i_f;
        case (i_op)
            awc_pkg::ALU_ADD: begin
                sum = {1'b0, i_w} + {1'b0, i_f};
                nib = {1'b0, i_w[3:0]} + {1'b0, i_f[3:0]};
                o_res = sum[7:0];
                o_c = sum[8];
                o_dc = nib[4];
            end
            awc_pkg::ALU_SUB: begin
                // Two's complement: carry high means no borrow
                sum = {1'b0, i_f} + {1'b0, ~i_w} + 9'h001; // RULE7 RULE12
                nib = {1'b0, i_f[3:0]} + {1'b0, ~i_w[3:0]} + 5'h01; // RULE12
                o_res = sum[7:0];
                o_c = sum[8];
                o_dc = nib[4];
            end
            awc_pkg::ALU_AND: o_res = i_w & i_f;
            awc_pkg::ALU_IOR: o_res = i_w | i_f;
            awc_pkg::ALU_XOR: o_res = i_w ^ i_f;
            awc_pkg::ALU_PASS_W: o_res = i_w;
            awc_pkg::ALU_PASS_F: o_res = i_f;
            awc_pkg::ALU_COM: o_res = ~i_f;
            awc_pkg::ALU_INC: o_res = i_f + 8'h01;
            awc_pkg::ALU_DEC: o_res = i_f - 8'h01;
            awc_pkg::ALU_RRF: begin
                o_res = {i_carry, i_f[7:1]}; // RULE6
                o_c = i_f[0];
            end
            awc_pkg::ALU_RLF: begin
                o_res = {i_f[6:0], i_carry}; // RULE6
                o_c = i_f[7];
            end
            awc_pkg::ALU_SWAP: o_res = {i_f[3:0], i_f[7:4]};
            awc_pkg::ALU_CLR: o_res = 8'h00;
            awc_pkg::ALU_BCLR: o_res = i_f & ~(8'h01 << i_bit);
            awc_pkg::ALU_BSET: o_res = i_f | (8'h01 << i_bit);
            default: o_res = i_f;
        endcase
        o_z = (o_res == 8'h00); // RULE19
    end

endmodule // awc_alu

// ===== awc_core.sv
// Execution core: phase divider, two-stage pipeline, decode, flags, stack
// Operation
// RULE1 - Instructions are 14 bits wide, separate from the 8-bit data word.
// RULE2 - One whole instruction is fetched per cycle on its own program bus.
// RULE3 - Fetch overlaps execution; non-branch instructions complete in one cycle.
// RULE4 - Core registers, program counter low byte included, sit in data space.
// RULE5 - Register file reachable directly and indirectly for every operation.
// RULE6 - ALU is 8 bits: add, subtract, shift and logical operations.
// RULE7 - Arithmetic treats operands and results as two's complement.
// RULE8 - Two-operand ops use accumulator plus file register or literal.
// RULE9 - Single-operand ops act on accumulator or file register.
// RULE10 - Accumulator is an 8-bit register with no data address.
// RULE11 - Carry, digit carry, zero change only for instructions that affect them.
// RULE12 - In subtraction carry means no borrow, digit carry no nibble borrow.
// RULE13 - In RC mode cycle clock output runs at a quarter of input.
// RULE14 - Master reset input resets the core while low.
// RULE15 - Four phases; counter increments in phase one, latch in phase four.
// RULE16 - Operand read in phase two, destination written in phase four.
// RULE17 - Program counter changes take two cycles, flushing the fetched word.
// RULE18 - Start at 0000h after reset; interrupt entry loads 0004h.
// RULE19 - Zero flag set on all-zero result, cleared otherwise, when affected.
`timescale 1ns/100ps
module awc_core #(
    parameter int STACK_DEPTH = awc_pkg::STACK_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_master_reset_n,
    // Configuration and interrupt request
    input wire logic i_rc_mode,
    input wire logic i_irq_req,
    // Program memory bus
    output logic [12:0] o_prog_addr,
    input wire logic [13:0] i_prog_data,
    // Data register file bus
    output logic [7:0] o_data_addr,
    output logic o_data_rd,
    input wire logic [7:0] i_data_rdata,
    output logic o_data_wr,
    output logic [7:0] o_data_wdata,
    // Status outputs
    output logic o_cycle_clock_output,
    output logic o_irq_ack
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    // ========================================================================
    // State
    // ========================================================================
    awc_pkg::awc_phase_t ph_r, ph_nxt;
    logic [12:0] program_counter_r, program_counter_nxt;
    logic [13:0] instruction_latch_r, instruction_latch_nxt;
    logic [7:0] w_r, w_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] fsr_r, fsr_nxt;
    logic [7:0] opnd_r, opnd_nxt;
    logic [12:0] stk_r [STACK_DEPTH];
    logic [12:0] stk_nxt [STACK_DEPTH];
    logic [SP_W-1:0] sp_r, sp_nxt;
    logic [12:0] prog_addr_nxt;
    logic [7:0] data_addr_nxt, data_wdata_nxt;
    logic data_rd_nxt, data_wr_nxt, cyc_nxt, irq_ack_nxt;

    // ========================================================================
    // Decode
    // ========================================================================
    awc_pkg::awc_alu_op_t op;
    logic [7:0] ea, alu_b, res;
    logic alu_c, alu_dc, alu_z, internal;
    logic use_lit, to_w, to_f, file_rd, fz, fc, fdc;
    logic skip_z, skip_set, skip_clr, jump, call, ret, skip, redirect, irq_take;
    logic [3:0] sub;

    // Core register decode for a data address
    function automatic logic is_core_reg(input logic [6:0] a);
        is_core_reg = (a == awc_pkg::SFR_INDIRECT) || (a == awc_pkg::SFR_PCL) ||
                      (a == awc_pkg::SFR_STATUS) || (a == awc_pkg::SFR_FSR);
    endfunction

    // Effective address: indirect through select register or banked direct
    always_comb begin
        ea = (instruction_latch_r[6:0] == awc_pkg::SFR_INDIRECT) ? fsr_r :
             {status_r[awc_pkg::ST_RP0], instruction_latch_r[6:0]}; // RULE5
        internal = is_core_reg(ea[6:0]); // RULE4
        alu_b = use_lit ? instruction_latch_r[7:0] : opnd_r; // RULE8 RULE9
    end

    // Instruction decode into ALU op, destination and flow control
    always_comb begin
        op = awc_pkg::ALU_PASS_F;
        use_lit = 1'b0;
        to_w = 1'b0;
        to_f = 1'b0;
        file_rd = 1'b0;
        fz = 1'b0;
        fc = 1'b0;
        fdc = 1'b0;
        skip_z = 1'b0;
        skip_set = 1'b0;
        skip_clr = 1'b0;
        jump = 1'b0;
        call = 1'b0;
        ret = 1'b0;
        sub = instruction_latch_r[11:8];
        case (instruction_latch_r[13:12]) // RULE1
            awc_pkg::GRP_BYTE: begin
                to_w = ~instruction_latch_r[7];
                to_f = instruction_latch_r[7];
                file_rd = 1'b1;
                case (sub)
                    4'h0: begin
                        op = awc_pkg::ALU_PASS_W;
                        to_w = 1'b0;
                        file_rd = 1'b0;
                        ret = (instruction_latch_r == awc_pkg::INSTR_RETURN) ||
                              (instruction_latch_r == awc_pkg::INSTR_RETFIE);
                    end
                    4'h1: begin
                        op = awc_pkg::ALU_CLR;
                        fz = 1'b1;
                    end
                    4'h2: begin
                        op = awc_pkg::ALU_SUB;
                        {fz, fc, fdc} = 3'h7;
                    end
                    4'h3: {op, fz} = {awc_pkg::ALU_DEC, 1'b1};
                    4'h4: {op, fz} = {awc_pkg::ALU_IOR, 1'b1};
                    4'h5: {op, fz} = {awc_pkg::ALU_AND, 1'b1};
                    4'h6: {op, fz} = {awc_pkg::ALU_XOR, 1'b1};
                    4'h7: begin
                        op = awc_pkg::ALU_ADD;
                        {fz, fc, fdc} = 3'h7;
                    end
                    4'h8: {op, fz} = {awc_pkg::ALU_PASS_F, 1'b1};
                    4'h9: {op, fz} = {awc_pkg::ALU_COM, 1'b1};
                    4'hA: {op, fz} = {awc_pkg::ALU_INC, 1'b1};
                    4'hB: {op, skip_z} = {awc_pkg::ALU_DEC, 1'b1};
                    4'hC: {op, fc} = {awc_pkg::ALU_RRF, 1'b1};
                    4'hD: {op, fc} = {awc_pkg::ALU_RLF, 1'b1};
                    4'hE: op = awc_pkg::ALU_SWAP;
                    default: {op, skip_z} = {awc_pkg::ALU_INC, 1'b1};
                endcase
            end
            awc_pkg::GRP_BIT: begin
                file_rd = 1'b1;
                case (instruction_latch_r[11:10])
                    2'h0: {op, to_f} = {awc_pkg::ALU_BCLR, 1'b1};
                    2'h1: {op, to_f} = {awc_pkg::ALU_BSET, 1'b1};
                    2'h2: skip_clr = 1'b1;
                    default: skip_set = 1'b1;
                endcase
            end
            awc_pkg::GRP_JUMP: begin
                jump = 1'b1;
                call = ~instruction_latch_r[11];
            end
            default: begin
                use_lit = 1'b1;
                to_w = 1'b1;
                case (sub)
                    4'h8: {op, fz} = {awc_pkg::ALU_IOR, 1'b1};
                    4'h9: {op, fz} = {awc_pkg::ALU_AND, 1'b1};
                    4'hA: {op, fz} = {awc_pkg::ALU_XOR, 1'b1};
                    4'hB: to_w = 1'b0;
                    4'hC, 4'hD: begin
                        op = awc_pkg::ALU_SUB;
                        {fz, fc, fdc} = 3'h7;
                    end
                    4'hE, 4'hF: begin
                        op = awc_pkg::ALU_ADD;
                        {fz, fc, fdc} = 3'h7;
                    end
                    default: ret = (sub[3:2] == 2'h1);
                endcase
            end
        endcase
    end

    // Shared ALU
    awc_alu u_alu (
        .i_op(op),
        .i_bit(instruction_latch_r[9:7]),
        .i_carry(status_r[awc_pkg::ST_C]),
        .i_w(w_r),
        .i_f(alu_b),
        .o_res(res),
        .o_c(alu_c),
        .o_dc(alu_dc),
        .o_z(alu_z)
    );

    // ========================================================================
    // Phase sequencing and pipeline next state
    // ========================================================================
    always_comb begin
        skip = (skip_z & alu_z) |
               (skip_set & opnd_r[instruction_latch_r[9:7]]) |
               (skip_clr & ~opnd_r[instruction_latch_r[9:7]]);
        redirect = jump | ret |
                   (to_f & (ea[6:0] == awc_pkg::SFR_PCL)); // RULE17
        irq_take = i_irq_req & ~redirect & ~skip;
        ph_nxt = ph_r;
        program_counter_nxt = program_counter_r;
        instruction_latch_nxt = instruction_latch_r;
        w_nxt = w_r;
        status_nxt = status_r;
        fsr_nxt = fsr_r;
        opnd_nxt = opnd_r;
        stk_nxt = stk_r;
        sp_nxt = sp_r;
        prog_addr_nxt = o_prog_addr;
        data_addr_nxt = o_data_addr;
        data_rd_nxt = o_data_rd;
        data_wr_nxt = o_data_wr;
        data_wdata_nxt = o_data_wdata;
        irq_ack_nxt = 1'b0;
        case (ph_r) // RULE15
            awc_pkg::PH_ONE: begin
                ph_nxt = awc_pkg::PH_TWO;
                prog_addr_nxt = program_counter_r; // RULE2
                program_counter_nxt = program_counter_r + 13'h0001; // RULE15
                data_addr_nxt = ea;
                data_rd_nxt = file_rd & ~internal;
            end
            awc_pkg::PH_TWO: begin
                ph_nxt = awc_pkg::PH_THREE;
                data_rd_nxt = 1'b0;
                case (ea[6:0]) // RULE16
                    awc_pkg::SFR_PCL: opnd_nxt = program_counter_r[7:0];
                    awc_pkg::SFR_STATUS: opnd_nxt = status_r;
                    awc_pkg::SFR_FSR: opnd_nxt = fsr_r;
                    awc_pkg::SFR_INDIRECT: opnd_nxt = 8'h00;
                    default: opnd_nxt = i_data_rdata;
                endcase
            end
            awc_pkg::PH_THREE: begin
                ph_nxt = awc_pkg::PH_FOUR;
                data_wr_nxt = to_f & ~internal; // RULE16
                data_wdata_nxt = res;
            end
            awc_pkg::PH_FOUR: begin
                ph_nxt = awc_pkg::PH_ONE;
                data_wr_nxt = 1'b0;
                if (to_w) begin
                    w_nxt = res; // RULE10
                end
                if (to_f && ea[6:0] == awc_pkg::SFR_STATUS) begin
                    status_nxt = res;
                end
                if (to_f && ea[6:0] == awc_pkg::SFR_FSR) begin
                    fsr_nxt = res;
                end
                if (to_f && ea[6:0] == awc_pkg::SFR_PCL) begin
                    program_counter_nxt = {program_counter_r[12:8], res}; // RULE4
                end
                // Flags from the ALU override a write to status
                if (fc) status_nxt[awc_pkg::ST_C] = alu_c; // RULE11 RULE12
                if (fdc) status_nxt[awc_pkg::ST_DC] = alu_dc; // RULE11
                if (fz) status_nxt[awc_pkg::ST_Z] = alu_z; // RULE11 RULE19
                if (jump) begin
                    program_counter_nxt = {program_counter_r[12:11],
                                           instruction_latch_r[10:0]};
                end
                if (ret) begin
                    sp_nxt = sp_r - 1'b1;
                    program_counter_nxt = stk_r[sp_nxt];
                end
                if (irq_take) begin
                    program_counter_nxt = awc_pkg::IRQ_VECTOR; // RULE18
                    irq_ack_nxt = 1'b1;
                end
                // Return address is the fetched word now being discarded
                if (call || irq_take) begin
                    stk_nxt[sp_r] = o_prog_addr;
                    sp_nxt = sp_r + 1'b1;
                end
                // Pipeline latch; flushed word becomes a no-op
                instruction_latch_nxt = (redirect || skip || irq_take) ?
                    awc_pkg::INSTR_NOP : i_prog_data; // RULE3 RULE17
            end
            default: ph_nxt = awc_pkg::PH_ONE;
        endcase
        cyc_nxt = i_rc_mode & ((ph_nxt == awc_pkg::PH_THREE) ||
                               (ph_nxt == awc_pkg::PH_FOUR)); // RULE13
        // Master reset holds everything but operand, stack entries, data address and write data while low
        if (!i_master_reset_n) begin // RULE14
            ph_nxt = awc_pkg::PH_ONE;
            program_counter_nxt = awc_pkg::RESET_VECTOR; // RULE18
            instruction_latch_nxt = awc_pkg::INSTR_NOP;
            w_nxt = awc_pkg::W_RST;
            status_nxt = awc_pkg::STATUS_RST;
            fsr_nxt = awc_pkg::FSR_RST;
            sp_nxt = '0;
            prog_addr_nxt = awc_pkg::RESET_VECTOR;
            data_rd_nxt = 1'b0;
            data_wr_nxt = 1'b0;
            cyc_nxt = 1'b0;
            irq_ack_nxt = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ph_r <= awc_pkg::PH_ONE;
            program_counter_r <= awc_pkg::RESET_VECTOR; // RULE18
            instruction_latch_r <= awc_pkg::INSTR_NOP;
            w_r <= awc_pkg::W_RST;
            status_r <= awc_pkg::STATUS_RST;
            fsr_r <= awc_pkg::FSR_RST;
            opnd_r <= 8'h00;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_r[i] <= 13'h0000;
            end
            sp_r <= '0;
            o_prog_addr <= awc_pkg::RESET_VECTOR;
            o_data_addr <= 8'h00;
            o_data_rd <= 1'b0;
            o_data_wr <= 1'b0;
            o_data_wdata <= 8'h00;
            o_cycle_clock_output <= 1'b0;
            o_irq_ack <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            program_counter_r <= program_counter_nxt;
            instruction_latch_r <= instruction_latch_nxt;
            w_r <= w_nxt;
            status_r <= status_nxt;
            fsr_r <= fsr_nxt;
            opnd_r <= opnd_nxt;
            stk_r <= stk_nxt;
            sp_r <= sp_nxt;
            o_prog_addr <= prog_addr_nxt;
            o_data_addr <= data_addr_nxt;
            o_data_rd <= data_rd_nxt;
            o_data_wr <= data_wr_nxt;
            o_data_wdata <= data_wdata_nxt;
            o_cycle_clock_output <= cyc_nxt;
            o_irq_ack <= irq_ack_nxt;
        end
    end

endmodule // awc_core

// ===== awc_core_props.sv
// Port timing checker for the execution core
`timescale 1ns/100ps
module awc_core_props (
    // Clock, resets and mode
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_master_reset_n,
    input wire logic i_rc_mode,
    // Buses and cycle clock
    input wire logic [12:0] o_prog_addr,
    input wire logic [7:0] o_data_addr,
    input wire logic o_data_rd,
    input wire logic o_data_wr,
    input wire logic o_cycle_clock_output,
    input wire logic o_irq_ack
);
    // ========================================
    // Clocking and phase sequences
    // ========================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn || !i_master_reset_n);
    sequence clk_high_s; o_cycle_clock_output [*2]; endsequence
    sequence clk_low_s; !o_cycle_clock_output [*2]; endsequence
    // ========================================
    // Assertions
    // ========================================
    rd_once_a: assert property (
        o_data_rd |=> !o_data_rd [*3]) else $error("read strobe repeats");
    wr_once_a: assert property (
        o_data_wr |=> !o_data_wr [*3]) else $error("write strobe repeats");
    rd_then_gap_a: assert property (
        o_data_rd |=> !o_data_wr) else $error("write right after read");
    addr_hold_a: assert property (
        o_data_rd |=> $stable(o_data_addr) [*2]) else $error("addr moved");
    fetch_hold_a: assert property (
        $changed(o_prog_addr) |=> $stable(o_prog_addr) [*3])
        else $error("fetch address too short");
    reset_vector_a: assert property (
        $rose(i_master_reset_n) |-> o_prog_addr == 13'h0000)
        else $error("start address wrong");
    cyc_wave_a: assert property (
        i_rc_mode && $rose(o_cycle_clock_output) |->
        clk_high_s ##1 clk_low_s ##1 o_cycle_clock_output)
        else $error("cycle clock not quarter rate");
    cyc_idle_a: assert property (
        !i_rc_mode [*2] |-> !o_cycle_clock_output)
        else $error("cycle clock runs outside RC mode");
    rd_phase_a: assert property (
        i_rc_mode && o_data_rd |-> !o_cycle_clock_output ##2
        o_cycle_clock_output) else $error("read not in phase two");
    wr_phase_a: assert property (
        i_rc_mode && o_data_wr |-> o_cycle_clock_output ##1
        !o_cycle_clock_output) else $error("write not in phase four");
    fetch_phase_a: assert property (
        i_rc_mode && $changed(o_prog_addr) |-> !o_cycle_clock_output)
        else $error("fetch outside early phases");
    irq_vector_a: assert property (
        o_irq_ack |=> o_prog_addr == 13'h0004)
        else $error("interrupt entry address wrong");
endmodule // awc_core_props

bind awc_core awc_core_props props_u (.i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn), .i_master_reset_n(i_master_reset_n),
    .i_rc_mode(i_rc_mode), .o_prog_addr(o_prog_addr),
    .o_data_addr(o_data_addr), .o_data_rd(o_data_rd),
    .o_data_wr(o_data_wr), .o_cycle_clock_output(o_cycle_clock_output),
    .o_irq_ack(o_irq_ack));

// ===== awc_file_model.sv
// Data register file model on the far side of the file bus
`timescale 1ns/100ps
module awc_file_model (
    // Clock
    input wire logic i_sys_clk,
    // File bus from the core
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    // Read data to the core
    output logic [7:0] o_rdata
);
    logic [7:0] mem_r [256];
    logic [7:0] junk_r = 8'hA5;
    initial foreach (mem_r[i]) mem_r[i] = 8'h00;
    // Store on write strobe, toggle filler every clock
    always @(posedge i_sys_clk) begin
        if (i_wr) mem_r[i_addr] <= i_wdata;
        junk_r <= ~junk_r;
    end
    // Data only while read strobe is up
    assign o_rdata = i_rd ? mem_r[i_addr] : junk_r;
endmodule // awc_file_model

// ===== awc_core_bench.sv
// Self-checking bench for the execution core
`timescale 1ns/100ps
module awc_core_bench;
    // ========================================
    // Signals
    // ========================================
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_master_reset_n = 1'b0;
    logic i_rc_mode = 1'b1;
    logic [13:0] i_prog_data = 14'h0000;
    logic [12:0] o_prog_addr;
    logic [7:0] o_data_addr, i_data_rdata, o_data_wdata;
    logic o_data_rd, o_data_wr, o_cycle_clock_output;
    logic i_irq_req = 1'b0;
    logic o_irq_ack;
    logic [13:0] rom [64];
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'h98D4967D;
    int error_cnt = 0;
    int cmp_count = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    awc_core dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_master_reset_n(i_master_reset_n), .i_rc_mode(i_rc_mode),
        .i_irq_req(i_irq_req), .o_prog_addr(o_prog_addr),
        .i_prog_data(i_prog_data), .o_data_addr(o_data_addr),
        .o_data_rd(o_data_rd), .i_data_rdata(i_data_rdata),
        .o_data_wr(o_data_wr), .o_data_wdata(o_data_wdata),
        .o_cycle_clock_output(o_cycle_clock_output),
        .o_irq_ack(o_irq_ack));
    awc_file_model file_u (.i_sys_clk(i_sys_clk), .i_addr(o_data_addr),
        .i_rd(o_data_rd), .i_wr(o_data_wr), .i_wdata(o_data_wdata),
        .o_rdata(i_data_rdata));

    // Program memory answers the fetch address
    always @(posedge i_sys_clk) i_prog_data <= rom[o_prog_addr[5:0]];

    // ========================================
    // Helpers
    // ========================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Each file write is matched to the oldest note
    always @(posedge i_sys_clk) begin
        if (o_data_wr === 1'b1) begin
            check({o_data_addr, o_data_wdata}, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
        end
    end

    // ========================================
    // Program run: literal add/subtract, store, status capture
    // ========================================
    task automatic run_prog(input int test, input logic rc);
        logic [7:0] a, b, r;
        logic [8:0] s;
        logic c, dc;
        int p, n;
        p = 0;
        i_master_reset_n <= 1'b0;
        i_rc_mode <= rc;
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            a = seed[7:0];
            b = seed[15:8];
            if (k == 0) begin a = 8'h0F; b = 8'h01; end
            if (k == 1) begin a = 8'h80; b = 8'h80; end
            if (k == 2) begin a = 8'hFF; b = 8'h01; end
            if (k[0]) begin
                s = {1'b0, b} - {1'b0, a};
                c = (b >= a);
                dc = (b[3:0] >= a[3:0]);
            end else begin
                s = a + b;
                c = s[8];
                dc = (a[3:0] + b[3:0]) > 15;
            end
            r = s[7:0];
            rom[p] = 14'h3000 | 14'(a);
            rom[p+1] = (k[0] ? 14'h3C00 : 14'h3E00) | 14'(b);
            rom[p+2] = 14'h00A0;
            rom[p+3] = 14'h0803;
            rom[p+4] = 14'h00A1;
            p += 5;
            exp_q.push_back({8'h20, r});
            exp_q.push_back({8'h21, 5'h00, r == 8'h00, dc, c});
        end
        rom[40] = 14'h0820;
        rom[41] = 14'h00A3;
        rom[42] = 14'h282A; // Jump to itself
        rom[43] = 14'h00A2; // Must be flushed
        exp_q.push_back({8'h23, r});
        repeat (2) @(posedge i_sys_clk);
        i_master_reset_n <= 1'b1;
        for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge i_sys_clk);
        check(16'(n <= 184), 16'h0001);
        repeat (40) @(posedge i_sys_clk);
        check(16'(exp_q.size()), 16'h0000);
        // Interrupt entry from the flushed slot of the self loop
        rom[4] = 14'h2804;
        i_irq_req <= 1'b1;
        for (n = 0; n < 40 && o_irq_ack !== 1'b1; n++) @(posedge i_sys_clk);
        i_irq_req <= 1'b0;
        check(16'(n < 40), 16'h0001);
        repeat (8) @(posedge i_sys_clk);
        check(16'({o_prog_addr[12:1], 1'b0}), 16'h0004);
        $display("test %0d done", test);
    endtask

    // ========================================
    // Main sequence and watchdog
    // ========================================
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        run_prog(1, 1'b1);
        run_prog(2, 1'b0);
        wrap_up();
    end

    initial begin
        #(3000 * 25);
        error_cnt++;
        wrap_up();
    end
endmodule // awc_core_bench
